// [design/prp_rx_port.sv]
// receive side of the mac-facing port: mii/rmii/symbol output, straps, mii receive clock
`default_nettype none
module prp_rx_port
    import prp_pkg::*;
#(
    parameter int unsigned DEPTH = FIFO_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic             speed_100,
    input  wire logic             symbol_mode,
    input  wire logic [SYM_W-1:0] up_data,
    input  wire logic             up_err,
    input  wire logic             up_valid,
    output var  logic             up_ready,
    input  wire logic             link_clk,
    input  wire logic [PAD_W-1:0] pad_in,
    output var  logic [3:0]       rxd_o,
    output var  logic [3:0]       rxd_oe,
    output var  logic             rxdv_o,
    output var  logic             rxdv_oe,
    output var  logic             rx_symbol_msb_o,
    output var  logic             rx_symbol_msb_oe,
    output var  logic             rxclk_o,
    output var  logic             rxclk_oe,
    output var  logic [2:0]       op_mode,
    output var  logic [2:0]       mgmt_addr,
    output var  logic             reduced_iface_select_strap,
    output var  logic             straps_captured
);
    localparam int unsigned HC_W = 6;
    localparam logic [HC_W-1:0] HC_100_LAST = HC_W'(HALF_100 - 1);
    localparam logic [HC_W-1:0] HC_10_LAST  = HC_W'(HALF_10 - 1);
    localparam logic [3:0]      REP_LAST    = 4'(RMII10_REPEAT - 1);
    localparam logic [1:0]      SETTLE_LAST = 2'(STRAP_SETTLE - 1);

    if (HALF_10 >= (1 << HC_W) || RMII10_REPEAT > 16 || STRAP_SETTLE > 4) begin : g_bad_cnt
        $error("counter widths too narrow for timing constants");
    end

    // =====================================================================
    // input synchronisers
    logic [PAD_W-1:0] pad_s1_q;
    logic [PAD_W-1:0] pad_s2_q;
    logic             lclk_s1_q;
    logic             lclk_s2_q;
    logic             lclk_s3_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pad_s1_q  <= '0;
            pad_s2_q  <= '0;
            lclk_s1_q <= 1'b0;
            lclk_s2_q <= 1'b0;
            lclk_s3_q <= 1'b0;
        end else begin
            pad_s1_q  <= pad_in;
            pad_s2_q  <= pad_s1_q;
            lclk_s1_q <= link_clk;
            lclk_s2_q <= lclk_s1_q;
            lclk_s3_q <= lclk_s2_q;
        end
    end

    // =====================================================================
    // strap capture and drive enable
    logic [1:0] settle_q;
    logic       drive_q;
    wire        capture = !drive_q && (settle_q == SETTLE_LAST);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            settle_q <= '0;
            drive_q  <= 1'b0;
        end else if (!drive_q) begin
            settle_q <= settle_q + 2'h1;
            drive_q  <= capture;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            op_mode                    <= OP_MODE_RST;
            mgmt_addr                  <= MGMT_ADDR_RST;
            reduced_iface_select_strap <= RMII_SEL_RST;
            straps_captured            <= 1'b0;
        end else if (capture) begin
            op_mode                    <= {pad_s2_q[PAD_OPM2], pad_s2_q[PAD_OPM1],
                                           pad_s2_q[PAD_OPM0]};
            mgmt_addr                  <= {pad_s2_q[PAD_ADDR2], pad_s2_q[PAD_ADDR1],
                                           pad_s2_q[PAD_ADDR0]};
            reduced_iface_select_strap <= pad_s2_q[PAD_IFSEL];
            straps_captured            <= 1'b1;
        end
    end

    // =====================================================================
    // pacing: mii receive clock divider, rmii reference edges
    logic [HC_W-1:0] hc_q;
    logic [3:0]      rep_q;
    wire             rmii      = reduced_iface_select_strap;
    wire             mii       = !rmii;
    wire             hc_wrap   = hc_q == (speed_100 ? HC_100_LAST : HC_10_LAST);
    wire             mii_tick  = mii && hc_wrap && rxclk_o;
    wire             lclk_rise = lclk_s2_q && !lclk_s3_q;
    wire             rep_last  = speed_100 || (rep_q == REP_LAST);
    wire             rmii_tick = rmii && lclk_rise && rep_last;
    wire             tick      = drive_q && (mii_tick || rmii_tick);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hc_q     <= '0;
            rxclk_o  <= 1'b0;
            rxclk_oe <= 1'b0;
            rep_q    <= '0;
        end else begin
            hc_q     <= (hc_wrap || !drive_q || rmii) ? '0 : hc_q + HC_W'(1);
            rxclk_o  <= drive_q && mii && (rxclk_o ^ hc_wrap);
            rxclk_oe <= drive_q && mii;
            if (lclk_rise) begin
                rep_q <= rep_last ? '0 : rep_q + 4'h1;
            end
        end
    end

    // =====================================================================
    // buffer between decoder and pins
    logic              fifo_vld;
    logic [WORD_W-1:0] fifo_word;
    logic              ph_q;
    logic              have_q;
    logic [WORD_W-1:0] cur_q;
    logic [3:0]        prev_nib_q;
    logic              sfd_seen_q;
    wire               load = tick && (mii || ph_q || !have_q);

    prp_fifo #(
        .W     (WORD_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (clk),
        .arst_n    (arst_n),
        .in_valid  (up_valid),
        .in_data   ({up_err, up_data}),
        .in_ready  (up_ready),
        .out_valid (fifo_vld),
        .out_data  (fifo_word),
        .out_ready (load)
    );

    // =====================================================================
    // output selection
    wire [WORD_W-1:0] word     = load ? fifo_word : cur_q;
    wire              vld      = load ? fifo_vld : have_q;
    wire              ph_next  = !load;
    wire [1:0]        dibit    = ph_next ? word[3:2] : word[1:0];
    wire              rmii10   = rmii && !speed_100;
    wire              sfd_now  = load && fifo_vld && rmii10 && (fifo_word[3:0] == SFD_HI)
                                 && (prev_nib_q == SFD_LO);
    wire              sfd_open = !rmii10 || sfd_seen_q || sfd_now;
    wire [1:0]        dibit_g  = sfd_open ? dibit : 2'b00;
    wire [3:0]        rxd_d    = !vld ? 4'h0 : mii ? word[3:0] : {2'b00, dibit_g};
    wire              sym_sel  = symbol_mode && mii;
    wire              rxsym_d  = vld && (sym_sel ? word[WORD_SYM_MSB] : word[WORD_ERR]);
    wire [3:0]        prev_d   = !vld ? 4'h0 : load ? word[3:0] : prev_nib_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cur_q      <= '0;
            have_q     <= 1'b0;
            ph_q       <= 1'b0;
            prev_nib_q <= '0;
            sfd_seen_q <= 1'b0;
            rxd_o      <= '0;
            rxdv_o     <= 1'b0;
            rx_symbol_msb_o <= 1'b0;
        end else if (tick) begin
            cur_q      <= word;
            have_q     <= vld;
            ph_q       <= ph_next;
            prev_nib_q <= prev_d;
            sfd_seen_q <= vld && (sfd_seen_q || sfd_now);
            rxd_o      <= rxd_d;
            rxdv_o     <= vld;
            rx_symbol_msb_o <= rxsym_d;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rxd_oe           <= '0;
            rxdv_oe          <= 1'b0;
            rx_symbol_msb_oe <= 1'b0;
        end else begin
            rxd_oe           <= {4{drive_q}};
            rxdv_oe          <= drive_q;
            rx_symbol_msb_oe <= drive_q;
        end
    end

    // =====================================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence clk_high_100;
        rxclk_o [*4] ##1 !rxclk_o;
    endsequence

    pins_quiet_reset_a: assert property (
        !straps_captured |-> (rxd_oe == 4'h0) && !rxdv_oe && !rx_symbol_msb_oe && !rxclk_oe)
        else $error("receive pins driven before straps captured");
    rmii_upper_idle_a: assert property (
        reduced_iface_select_strap |-> rxd_o[3:2] == 2'b00)
        else $error("upper receive lines carry data in rmii");
    dv_from_tick_a: assert property (
        $rose(rxdv_o) |-> $past(tick) && $past(fifo_vld))
        else $error("data valid rose without buffered data");
    err_follows_word_a: assert property (
        load && fifo_vld && fifo_word[WORD_ERR] && !sym_sel |=> rx_symbol_msb_o)
        else $error("receive error not shown for errored word");
    fifth_line_err_a: assert property (
        !sym_sel && rx_symbol_msb_o |-> rxdv_o)
        else $error("error output outside valid data");
    err_clean_word_a: assert property (
        load && fifo_vld && !fifo_word[WORD_ERR] && !sym_sel |=> !rx_symbol_msb_o)
        else $error("symbol bit shown on error line outside symbol mode");
    rxclk_100_a: assert property (
        $rose(rxclk_o) && speed_100 && $stable(speed_100) |-> clk_high_100)
        else $error("receive clock high time wrong at 100");
    rxclk_10_a: assert property (
        $rose(rxclk_o) && !speed_100 |-> ##39 rxclk_o ##1 !rxclk_o)
        else $error("receive clock high time wrong at 10");
    straps_held_a: assert property (
        straps_captured |=> $stable(op_mode) && $stable(mgmt_addr)
                            && $stable(reduced_iface_select_strap))
        else $error("strap values changed after capture");
    sfd_gate_a: assert property (
        $rose(rxdv_o) && reduced_iface_select_strap && !speed_100 |-> rxd_o == 4'h0)
        else $error("rmii 10m dibit nonzero before sfd");
endmodule
`default_nettype wire

// [design/prp_pkg.sv]
// shared constants of the receive port: timing, word layout, strap pads, reset values
`default_nettype none
package prp_pkg;
    // =====================================================================
    // timing
    localparam int unsigned CLK_FREQ_KHZ   = 200000;
    localparam int unsigned RXCLK_100_KHZ  = 25000;
    localparam int unsigned RXCLK_10_KHZ   = 2500;
    localparam int unsigned HALF_100       = CLK_FREQ_KHZ / (2 * RXCLK_100_KHZ);
    localparam int unsigned HALF_10        = CLK_FREQ_KHZ / (2 * RXCLK_10_KHZ);
    localparam int unsigned RMII10_REPEAT  = 10;
    localparam int unsigned STRAP_SETTLE   = 3;
    // =====================================================================
    // fifo word layout
    localparam int unsigned NIB_W          = 4;
    localparam int unsigned SYM_W          = 5;
    localparam int unsigned WORD_W         = 6;
    localparam int unsigned WORD_SYM_MSB   = 4;
    localparam int unsigned WORD_ERR       = 5;
    localparam int unsigned FIFO_DEPTH     = 4;
    localparam logic [3:0]  SFD_LO         = 4'h5;
    localparam logic [3:0]  SFD_HI         = 4'hd;
    // =====================================================================
    // strap pads
    localparam int unsigned PAD_W          = 7;
    localparam int unsigned PAD_OPM0       = 0;
    localparam int unsigned PAD_OPM1       = 1;
    localparam int unsigned PAD_IFSEL      = 2;
    localparam int unsigned PAD_ADDR2      = 3;
    localparam int unsigned PAD_ADDR0      = 4;
    localparam int unsigned PAD_ADDR1      = 5;
    localparam int unsigned PAD_OPM2       = 6;
    localparam logic [2:0]  OP_MODE_RST    = 3'h7;
    localparam logic [2:0]  MGMT_ADDR_RST  = 3'h0;
    localparam logic        RMII_SEL_RST   = 1'b0;
endpackage
`default_nettype wire

// [design/prp_fifo.sv]
// small first-in first-out buffer with valid/ready on both sides
`default_nettype none
module prp_fifo
    import prp_pkg::*;
#(
    parameter int unsigned W     = WORD_W,
    parameter int unsigned DEPTH = FIFO_DEPTH
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output var  logic         in_ready,
    output var  logic         out_valid,
    output var  logic [W-1:0] out_data,
    input  wire logic         out_ready
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("fifo depth must be a power of two of at least 2");
    end

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    wire           push = in_valid & in_ready;
    wire           pop  = out_valid & out_ready;

    assign cnt_d     = cnt_q + CW'(push) - CW'(pop);
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem[rd_q];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_q     <= '0;
            rd_q     <= '0;
            cnt_q    <= '0;
            in_ready <= 1'b1;
        end else begin
            wr_q     <= wr_q + AW'(push);
            rd_q     <= rd_q + AW'(pop);
            cnt_q    <= cnt_d;
            in_ready <= (cnt_d != FULL_CNT);
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end
endmodule
`default_nettype wire

// [test/prp_mac_model.sv]
// mac-side sampler of the receive port pins
`default_nettype none
module prp_mac_model (
    input wire logic       rmii,
    input wire logic       link_clk,
    input wire logic       rxclk_pin,
    input wire logic       rxdv_pin,
    input wire logic       fifth_pin,
    input wire logic [3:0] rxd_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    // =====================================================================
    // sampled words, fifth line on top
    logic [4:0] q[$];
    int         upper_hits = 0;
    always @(posedge rxclk_pin) begin
        if (!rmii && rxdv_pin) begin
            q.push_back({fifth_pin, rxd_pin});
        end
    end
    // rmii: error line and upper lines left unused, upper lines only monitored
    always @(posedge link_clk) begin
        if (rmii && rxdv_pin) begin
            q.push_back({3'h0, rxd_pin[1:0]});
            if (rxd_pin[3:2] !== 2'b00) begin
                upper_hits++;
            end
        end
    end
endmodule
`default_nettype wire

// [test/prp_rx_port_tb.sv]
// self-checking bench of the receive port: straps, mii, symbol and rmii paths
`default_nettype none
module prp_rx_port_tb import prp_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    // =====================================================================
    // stimulus, outputs and resolved pins
    logic             clk         = 1'b0;
    logic             link_clk    = 1'b0;
    logic             arst_n      = 1'b0;
    logic             speed_100   = 1'b1;
    logic             symbol_mode = 1'b0;
    logic [SYM_W-1:0] up_data     = 5'h00;
    logic             up_err      = 1'b0;
    logic             up_valid    = 1'b0;
    logic [PAD_W-1:0] strap_lvl   = 7'h43;
    logic             up_ready, rxdv_o, rxdv_oe, msb_o, msb_oe, rxclk_o, rxclk_oe;
    logic             iface, captured;
    logic [3:0]       rxd_o, rxd_oe;
    logic [2:0]       op_mode, mgmt_addr;
    wire logic [3:0]  rxd_pin   = (rxd_oe & rxd_o) | (~rxd_oe & strap_lvl[3:0]);
    wire logic        fifth_pin = msb_oe ? msb_o : strap_lvl[4];
    wire logic        rxclk_pin = rxclk_oe ? rxclk_o : strap_lvl[5];
    wire logic        rxdv_pin  = rxdv_oe ? rxdv_o : 1'b0;
    wire logic [6:0]  pad       = {strap_lvl[6], rxclk_pin, fifth_pin, rxd_pin};
    int               bad_count   = 0;
    int               comparisons = 0;
    always #2.5 clk = ~clk;
    initial begin
        #1.3;
        forever #80 link_clk = ~link_clk;
    end
    prp_rx_port dut_u (.clk(clk), .arst_n(arst_n), .speed_100(speed_100),
        .symbol_mode(symbol_mode), .up_data(up_data), .up_err(up_err), .up_valid(up_valid),
        .up_ready(up_ready), .link_clk(link_clk), .pad_in(pad), .rxd_o(rxd_o),
        .rxd_oe(rxd_oe), .rxdv_o(rxdv_o), .rxdv_oe(rxdv_oe), .rx_symbol_msb_o(msb_o),
        .rx_symbol_msb_oe(msb_oe), .rxclk_o(rxclk_o), .rxclk_oe(rxclk_oe),
        .op_mode(op_mode), .mgmt_addr(mgmt_addr), .reduced_iface_select_strap(iface),
        .straps_captured(captured));
    prp_mac_model mac_u (.rmii(strap_lvl[2]), .link_clk(link_clk), .rxclk_pin(rxclk_pin),
        .rxdv_pin(rxdv_pin), .fifth_pin(fifth_pin), .rxd_pin(rxd_pin));
    // =====================================================================
    // tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic do_reset(input logic [6:0] s);
        @(negedge clk);
        arst_n = 1'b0;
        strap_lvl = s;
        repeat (6) @(negedge clk);
        chk({rxd_oe, rxdv_oe, msb_oe, rxclk_oe, 1'b0}, 8'h00);
        chk({1'b0, op_mode, mgmt_addr, iface}, 8'h70);
        arst_n = 1'b1;
        repeat (8) @(negedge clk);
        chk({captured, rxd_oe, rxdv_oe, msb_oe, rxclk_oe}, {1'b1, 4'hf, 2'b11, !s[2]});
    endtask
    task automatic push(input logic [4:0] d, input logic e);
        int n;
        n = 0;
        up_valid = 1'b1;
        up_data = d;
        up_err = e;
        while (up_ready !== 1'b1 && n < 5000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 5000) begin
            chk({7'h0, up_ready}, 8'h01);
        end
        @(negedge clk);
    endtask
    task automatic expect_word(input logic [4:0] exp, input int rep);
        int n;
        for (int j = 0; j < rep; j++) begin
            n = 0;
            while (mac_u.q.size() == 0 && n < 20000) begin
                @(negedge clk);
                n++;
            end
            if (mac_u.q.size() == 0) begin
                chk(8'hff, {3'h0, exp});
            end else begin
                chk({3'h0, mac_u.q.pop_front()}, {3'h0, exp});
            end
        end
    endtask
    task automatic period(input int exp);
        realtime t0;
        @(posedge rxclk_pin);
        t0 = $realtime;
        @(posedge rxclk_pin);
        chk(8'(int'(($realtime - t0) / 5.0)), 8'(exp));
    endtask
    // =====================================================================
    // tests
    initial begin
        #200000;
        bad_count++;
        report_and_stop();
    end
    initial begin
        do_reset(7'h43);
        chk({1'b0, op_mode, mgmt_addr, iface}, 8'h70);
        $display("done: default straps");
        period(8);
        @(negedge clk);
        for (int i = 0; i < 6; i++) push(5'h10 | 5'(i * 3), i == 4);
        up_valid = 1'b0;
        for (int i = 0; i < 6; i++) expect_word({i == 4, 4'(i * 3)}, 1);
        repeat (16) @(negedge clk);
        chk({7'h0, rxdv_o}, 8'h00);
        $display("done: mii 100");
        symbol_mode = 1'b1;
        push(5'h1a, 1'b0);
        push(5'h0b, 1'b1);
        up_valid = 1'b0;
        expect_word(5'h1a, 1);
        expect_word(5'h0b, 1);
        repeat (16) @(negedge clk);
        symbol_mode = 1'b0;
        speed_100 = 1'b0;
        $display("done: symbol mode");
        period(80);
        @(negedge rxclk_pin);
        @(negedge clk);
        for (int i = 1; i < 5; i++) push(5'(i), 1'b0);
        up_valid = 1'b0;
        repeat (2) @(negedge clk);
        chk({7'h0, up_ready}, 8'h00);
        push(5'h05, 1'b0);
        up_valid = 1'b0;
        for (int i = 1; i < 6; i++) expect_word(5'(i), 1);
        $display("done: mii 10 fill");
        do_reset(7'h1e);
        chk({1'b0, op_mode, mgmt_addr, iface}, 8'h2b);
        speed_100 = 1'b1;
        mac_u.q.delete();
        push(5'h06, 1'b0);
        push(5'h09, 1'b0);
        up_valid = 1'b0;
        expect_word(5'h02, 1);
        expect_word(5'h01, 1);
        expect_word(5'h01, 1);
        expect_word(5'h02, 1);
        repeat (400) @(negedge clk);
        $display("done: rmii 100");
        speed_100 = 1'b0;
        mac_u.q.delete();
        push(5'h05, 1'b0);
        push(5'h05, 1'b0);
        push(5'h0d, 1'b0);
        push(5'h0a, 1'b0);
        up_valid = 1'b0;
        expect_word(5'h00, 40);
        expect_word(5'h01, 10);
        expect_word(5'h03, 10);
        expect_word(5'h02, 20);
        chk(8'(mac_u.upper_hits), 8'h00);
        chk({1'b0, op_mode, mgmt_addr, iface}, 8'h2b);
        $display("done: rmii 10");
        report_and_stop();
    end
endmodule
`default_nettype wire
